// ===== logic/cht_chopper.sv
// Chopper phase sequencer with blanking, decay timers and hysteresis
// Notes on behaviour
// - Pattern 100 in bits 19..17 selects the chopper word; 17 bits follow.
// - Blanking code 00..11 gives 16, 24, 36 or 54 clocks.
// - Bit 14 picks hysteresis chopper or constant off-time with fast decay.
// - Constant off-time: fast decay follows on unless the fast value is zero, ends early at negative nominal.
// - Random bit adds zero to three clocks to the slow decay length.
// - Hysteresis mode: decrement every 16, 32, 48 or 64 clocks.
// - Off-time mode: bit 12 lets only the timer end fast decay; bit 11 MSB.
// - Hysteresis end is field minus three, in 1/512 units of current.
// - Off-time mode: same field minus three is the sine offset.
// - Hysteresis start is end plus field plus one.
// - Off-time mode: fast decay timer runs 32 clocks times the four-bit fast value.
// - Slow decay lasts 24 plus 32 times the off-time field.
// - Off-time zero disables the driver, every bridge switch off.
`timescale 1ns/1ps
`default_nettype none
`include "cht_defs.svh"
module cht_chopper #(
  parameter int CNT_W = 10
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cfg_wr,
  input  wire logic [19:0] cfg_word,
  input  wire logic        cmp_peak,
  input  wire logic        cmp_valley,
  input  wire logic        cmp_neg_nominal,
  output logic             phase_on,
  output logic             phase_fast,
  output logic             phase_slow,
  output logic             bridges_off,
  output logic             blanking,
  output logic [5:0]       hyst_level,
  output logic [5:0]       sine_offset
);
  cht_cfg_if cfg ();

  cht_cfg_reg u_reg (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (cfg_wr),
    .wr_word (cfg_word),
    .cfg     (cfg)
  );

  cht_pkg::cht_state_e state_q;
  cht_pkg::cht_state_e state_d;
  logic [CNT_W-1:0]    cnt_q;
  logic [CNT_W-1:0]    cnt_d;
  logic [5:0]          blank_q;
  logic [5:0]          blank_d;
  logic [6:0]          dec_q;
  cht_pkg::cht_hyst_t  hyst_q;
  logic [7:0]          lfsr_q;
  logic                on_q;
  logic                fast_q;
  logic                slow_q;
  logic                off_q;
  logic                blank_out_q;
  logic [5:0]          sine_q;

  wire                     disabled;
  wire                     mode_fix;
  wire                     blank_done;
  wire                     cnt_last;
  wire                     enter;
  wire [5:0]               blank_len;
  wire [3:0]               fast_n;
  wire [CNT_W-1:0]         fast_len;
  wire [1:0]               rnd;
  wire [CNT_W-1:0]         slow_len;
  wire [6:0]               decr_len;
  wire [2:0]               decr_sel;
  cht_pkg::cht_hyst_t      end_eff;
  cht_pkg::cht_hyst_t      hstart_eff;
  wire                     on_exit;
  wire                     fast_exit;
  wire                     reload_hyst;

  assign disabled   = (cfg.offtime_setting == 4'h0);
  assign mode_fix   = cfg.chop_mode_sel;
  assign blank_done = (blank_q == 6'h00);
  assign cnt_last   = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
  assign enter      = (state_d != state_q);

  assign blank_len = (cfg.blank_time_sel == 2'h0) ? `CHT_BLANK_0 :
                     (cfg.blank_time_sel == 2'h1) ? `CHT_BLANK_1 :
                     (cfg.blank_time_sel == 2'h2) ? `CHT_BLANK_2 :
                                                    `CHT_BLANK_3;

  // Fast value: bit 11 on top of the start field
  assign fast_n   = {cfg.hyst_decr_interval[0], cfg.hyst_start_value};
  assign fast_len = CNT_W'({fast_n, 5'h00});

  assign rnd      = cfg.rand_offtime_en ? lfsr_q[1:0] : 2'h0;
  assign slow_len = `CHT_SLOW_BASE
                  + CNT_W'({cfg.offtime_setting, 5'h00})
                  + CNT_W'(rnd);

  assign decr_sel = {1'b0, cfg.hyst_decr_interval} + 3'h1;
  assign decr_len = {decr_sel, 4'h0};

  assign end_eff    = {2'h0, cfg.hyst_end_value} - `CHT_END_OFS;
  assign hstart_eff = end_eff + {3'h0, cfg.hyst_start_value}
                    + `CHT_START_OFS;

  // Comparators are only heard once blanking has run out
  assign on_exit   = blank_done && cmp_peak;
  assign fast_exit = mode_fix
    ? (cnt_last || (!cfg.hyst_decr_interval[1] && blank_done &&
                    cmp_neg_nominal))
    : (blank_done && cmp_valley);
  assign reload_hyst = (state_q == cht_pkg::ST_SLOW) &&
                       (state_d == cht_pkg::ST_ON);

  always_comb begin
    state_d = state_q;
    case (state_q)
      cht_pkg::ST_OFF: begin
        state_d = cht_pkg::ST_ON;
      end
      cht_pkg::ST_ON: begin
        if (on_exit) begin
          if (mode_fix && fast_n == 4'h0) begin
            state_d = cht_pkg::ST_SLOW;
          end else begin
            state_d = cht_pkg::ST_FAST;
          end
        end
      end
      cht_pkg::ST_FAST: begin
        if (fast_exit) begin
          state_d = cht_pkg::ST_SLOW;
        end
      end
      cht_pkg::ST_SLOW: begin
        if (cnt_last) begin
          state_d = cht_pkg::ST_ON;
        end
      end
      default: begin
        state_d = cht_pkg::ST_OFF;
      end
    endcase
    if (disabled) begin
      state_d = cht_pkg::ST_OFF;
    end
  end

  always_comb begin
    cnt_d   = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    blank_d = (blank_q != 6'h00) ? blank_q - 6'h01 : blank_q;
    if (enter) begin
      cnt_d   = (state_d == cht_pkg::ST_SLOW) ? slow_len : fast_len;
      blank_d = (state_d == cht_pkg::ST_OFF ||
                 state_d == cht_pkg::ST_SLOW) ? 6'h00 : blank_len;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= cht_pkg::ST_OFF;
      cnt_q   <= '0;
      blank_q <= 6'h00;
      lfsr_q  <= `CHT_LFSR_SEED;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      blank_q <= blank_d;
      lfsr_q  <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  // Hysteresis restarts each on phase, then steps down toward the end value
  always_ff @(posedge clk) begin
    if (rst) begin
      hyst_q <= 6'h00;
      dec_q  <= 7'h00;
    end else if (mode_fix || disabled) begin
      hyst_q <= 6'h00;
      dec_q  <= decr_len;
    end else if (reload_hyst || cfg.upd || state_q == cht_pkg::ST_OFF) begin
      hyst_q <= hstart_eff;
      dec_q  <= decr_len;
    end else if (dec_q <= 7'h01) begin
      dec_q  <= decr_len;
      if (hyst_q > end_eff) begin
        hyst_q <= hyst_q - 6'h01;
      end
    end else begin
      dec_q <= dec_q - 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      on_q        <= 1'b0;
      fast_q      <= 1'b0;
      slow_q      <= 1'b0;
      off_q       <= 1'b1;
      blank_out_q <= 1'b0;
      sine_q      <= 6'h00;
    end else begin
      on_q        <= (state_d == cht_pkg::ST_ON);
      fast_q      <= (state_d == cht_pkg::ST_FAST);
      slow_q      <= (state_d == cht_pkg::ST_SLOW);
      off_q       <= (state_d == cht_pkg::ST_OFF);
      blank_out_q <= (blank_d != 6'h00);
      sine_q      <= mode_fix ? end_eff : 6'h00;
    end
  end

  assign phase_on    = on_q;
  assign phase_fast  = fast_q;
  assign phase_slow  = slow_q;
  assign bridges_off = off_q;
  assign blanking    = blank_out_q;
  assign hyst_level  = hyst_q;
  assign sine_offset = sine_q;

  // Checking helpers: slow phase length, load value and random enable
  logic [CNT_W-1:0] slow_run_q;
  logic [CNT_W-1:0] slow_exp_q;
  logic             slow_rnd_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      slow_run_q <= '0;
      slow_exp_q <= '0;
      slow_rnd_q <= 1'b0;
    end else if (state_q != cht_pkg::ST_SLOW &&
                 state_d == cht_pkg::ST_SLOW) begin
      slow_run_q <= '0;
      slow_exp_q <= slow_len;
      slow_rnd_q <= cfg.rand_offtime_en;
    end else if (state_q == cht_pkg::ST_SLOW) begin
      slow_run_q <= slow_run_q + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_slow_to_on;
    (state_q == cht_pkg::ST_SLOW) ##1 (state_q == cht_pkg::ST_ON);
  endsequence

  sequence seq_enter_on;
    (state_q != cht_pkg::ST_ON) ##1 (state_q == cht_pkg::ST_ON);
  endsequence

  chk_off_disable: assert property (
    disabled |=> (bridges_off && !phase_on && !phase_fast && !phase_slow))
    else $error("zero off-time did not switch bridges off");

  chk_blank_len: assert property (
    seq_enter_on |-> (blank_q == $past(blank_len)))
    else $error("blanking length wrong on entry to on phase");

  chk_blank_hold: assert property (
    (state_q == cht_pkg::ST_ON && blank_q != 6'h00 && !disabled)
      |=> (state_q == cht_pkg::ST_ON))
    else $error("on phase left during blanking");

  chk_fast_timer: assert property (
    (state_q == cht_pkg::ST_FAST && mode_fix &&
     cfg.hyst_decr_interval[1] && !cnt_last && !disabled)
      |=> (state_q == cht_pkg::ST_FAST))
    else $error("fast decay ended before its timer");

  chk_fast_neg_end: assert property (
    (state_q == cht_pkg::ST_FAST && mode_fix && !disabled &&
     !cfg.hyst_decr_interval[1] && blank_done && cmp_neg_nominal)
      |=> (state_q == cht_pkg::ST_SLOW))
    else $error("fast decay kept past negative nominal current");

  chk_slow_len: assert property (
    seq_slow_to_on |-> ($past(slow_run_q) == slow_exp_q - 1'b1))
    else $error("slow decay length differs from its load value");

  chk_slow_bound: assert property (
    (state_q == cht_pkg::ST_SLOW) |-> (slow_exp_q[4:2] == 3'h6 &&
      (slow_rnd_q || slow_exp_q[1:0] == 2'h0)))
    else $error("slow decay outside its random window");

  chk_hyst_start: assert property (
    (reload_hyst && !mode_fix && !disabled) |=>
      (hyst_q == $past(hstart_eff)))
    else $error("hysteresis not reloaded at on phase start");

  chk_sine_offset: assert property (
    mode_fix |=> (sine_offset == $past(end_eff)))
    else $error("sine offset not end field minus three");
endmodule
`default_nettype wire

// ===== logic/cht_defs.svh
// Bit positions, encodings and cycle counts of the chopper configuration
`ifndef CHT_DEFS_SVH
`define CHT_DEFS_SVH

`define CHT_SEL_MSB      19
`define CHT_SEL_LSB      17
`define CHT_SEL_PAT      3'h4
`define CHT_SET_W        17
`define CHT_SET_RESET    17'h00000

`define CHT_BLSEL_MSB    16
`define CHT_BLSEL_LSB    15
`define CHT_MODE_BIT     14
`define CHT_RND_BIT      13
`define CHT_DECR_MSB     12
`define CHT_DECR_LSB     11
`define CHT_END_MSB      10
`define CHT_END_LSB      7
`define CHT_START_MSB    6
`define CHT_START_LSB    4
`define CHT_OFFT_MSB     3
`define CHT_OFFT_LSB     0

`define CHT_BLANK_0      6'h10
`define CHT_BLANK_1      6'h18
`define CHT_BLANK_2      6'h24
`define CHT_BLANK_3      6'h36
`define CHT_SLOW_BASE    10'h018
`define CHT_END_OFS      6'h03
`define CHT_START_OFS    6'h01
`define CHT_LFSR_SEED    8'h01

`endif

// ===== logic/cht_pkg.sv
// Types used by the chopper timing module: phase state and hysteresis level
package cht_pkg;
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_ON   = 2'b01,
    ST_FAST = 2'b10,
    ST_SLOW = 2'b11
  } cht_state_e;

  typedef logic signed [5:0] cht_hyst_t;
endpackage

// ===== logic/cht_cfg_if.sv
// Decoded chopper settings passed from the register to the timing core
`timescale 1ns/1ps
`default_nettype none
interface cht_cfg_if;
  logic [1:0] blank_time_sel;
  logic       chop_mode_sel;
  logic       rand_offtime_en;
  logic [1:0] hyst_decr_interval;
  logic [3:0] hyst_end_value;
  logic [2:0] hyst_start_value;
  logic [3:0] offtime_setting;
  logic       upd;

  modport src (
    output blank_time_sel, chop_mode_sel, rand_offtime_en,
    output hyst_decr_interval, hyst_end_value, hyst_start_value,
    output offtime_setting, upd
  );
  modport snk (
    input blank_time_sel, chop_mode_sel, rand_offtime_en,
    input hyst_decr_interval, hyst_end_value, hyst_start_value,
    input offtime_setting, upd
  );
endinterface
`default_nettype wire

// ===== logic/cht_cfg_reg.sv
// Chopper configuration register with select decode and field split
`timescale 1ns/1ps
`default_nettype none
`include "cht_defs.svh"
module cht_cfg_reg (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [19:0] wr_word,
  cht_cfg_if.src           cfg
);
  logic [`CHT_SET_W-1:0] set_q;
  logic                  upd_q;
  wire                   sel_hit;

  assign sel_hit = wr_en &&
    (wr_word[`CHT_SEL_MSB:`CHT_SEL_LSB] == `CHT_SEL_PAT);

  // All setting bits are replaced in one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      set_q <= `CHT_SET_RESET;
      upd_q <= 1'b0;
    end else begin
      upd_q <= sel_hit;
      if (sel_hit) begin
        set_q <= wr_word[`CHT_SET_W-1:0];
      end
    end
  end

  assign cfg.blank_time_sel     = set_q[`CHT_BLSEL_MSB:`CHT_BLSEL_LSB];
  assign cfg.chop_mode_sel      = set_q[`CHT_MODE_BIT];
  assign cfg.rand_offtime_en    = set_q[`CHT_RND_BIT];
  assign cfg.hyst_decr_interval = set_q[`CHT_DECR_MSB:`CHT_DECR_LSB];
  assign cfg.hyst_end_value     = set_q[`CHT_END_MSB:`CHT_END_LSB];
  assign cfg.hyst_start_value   = set_q[`CHT_START_MSB:`CHT_START_LSB];
  assign cfg.offtime_setting    = set_q[`CHT_OFFT_MSB:`CHT_OFFT_LSB];
  assign cfg.upd                = upd_q;

  chk_sel_ignore: assert property (@(posedge clk) disable iff (rst)
    (wr_en && wr_word[19:17] != 3'h4) |=> $stable(set_q))
    else $error("write with foreign select changed settings");

  chk_sel_update: assert property (@(posedge clk) disable iff (rst)
    (wr_en && wr_word[19:17] == 3'h4) |=>
      (set_q == $past(wr_word[16:0])) && upd_q)
    else $error("selected write not taken whole");
endmodule
`default_nettype wire

// ===== test/cht_coil_model.sv
// Coil and comparator model driven by the chopper phase outputs
`timescale 1ns/1ps
`default_nettype none
module cht_coil_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       phase_on,
  input  wire logic       phase_fast,
  input  wire logic       bridges_off,
  input  wire logic [9:0] on_dly,
  input  wire logic [9:0] fast_dly,
  output logic            cmp_peak,
  output logic            cmp_valley,
  output logic            cmp_neg_nominal
);
  logic [9:0] cnt_q;
  logic       on_q;

  // Time since phase_on last changed stands in for the coil current
  always_ff @(posedge clk) begin
    on_q <= phase_on;
    if (rst || bridges_off || phase_on != on_q) begin
      cnt_q <= '0;
    end else if (cnt_q != 10'h3ff) begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  assign cmp_peak        = phase_on && cnt_q >= on_dly;
  assign cmp_valley      = phase_fast && cnt_q >= fast_dly;
  assign cmp_neg_nominal = phase_fast && cnt_q >= fast_dly;
endmodule
`default_nettype wire

// ===== test/chopper_timing_config_test.sv
// Self-checking bench for the chopper sequencer
`timescale 1ns/1ps
`default_nettype none
module chopper_timing_config_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_wr = 1'b0;
  logic [19:0] cfg_word = 20'h00000;
  logic [9:0]  on_dly = 10'h000;
  logic [9:0]  fast_dly = 10'h000;
  logic        cmp_peak, cmp_valley, cmp_neg_nominal;
  logic        phase_on, phase_fast, phase_slow, bridges_off, blanking;
  logic [5:0]  hyst_level, sine_offset;
  wire  [3:0]  ph = {blanking, phase_slow, phase_fast, phase_on};
  int          bad_count = 0;
  int          n_checks = 0;

  always #4 clk = ~clk;

  cht_chopper i_dut (
    .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_word(cfg_word),
    .cmp_peak(cmp_peak), .cmp_valley(cmp_valley),
    .cmp_neg_nominal(cmp_neg_nominal), .phase_on(phase_on),
    .phase_fast(phase_fast), .phase_slow(phase_slow),
    .bridges_off(bridges_off), .blanking(blanking),
    .hyst_level(hyst_level), .sine_offset(sine_offset)
  );

  cht_coil_model i_coil (
    .clk(clk), .rst(rst), .phase_on(phase_on), .phase_fast(phase_fast),
    .bridges_off(bridges_off), .on_dly(on_dly), .fast_dly(fast_dly),
    .cmp_peak(cmp_peak), .cmp_valley(cmp_valley),
    .cmp_neg_nominal(cmp_neg_nominal)
  );

  function automatic logic [19:0] mk(input int blk, mode, rnd, dec, endv,
                                     input int strt, offt);
    return {3'b100, blk[1:0], mode[0], rnd[0], dec[1:0], endv[3:0],
            strt[2:0], offt[3:0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s seen %0d exp %0d", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [19:0] w);
    @(negedge clk);
    cfg_wr   = 1'b1;
    cfg_word = w;
    @(negedge clk);
    cfg_wr   = 1'b0;
  endtask

  // Waits for output k to rise, then counts the cycles it stays high
  task automatic span(input int k, output int n);
    int t;
    t = 0;
    n = 0;
    while (ph[k] === 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    while (ph[k] !== 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    while (ph[k] === 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic t_select;
    check(bridges_off, 1'b1, "off after reset");
    check(ph, 4'h0, "phases after reset");
    wr({3'b000, 17'h08002});
    wr({3'b101, 17'h08002});
    repeat (5) @(negedge clk);
    check(bridges_off, 1'b1, "foreign select taken");
    $display("test select done");
  endtask

  task automatic t_slow;
    int n;
    int tv[3] = '{1, 2, 15};
    foreach (tv[i]) begin
      wr(mk(1, 1, 0, 0, 3, 0, tv[i]));
      span(2, n);
      span(2, n);
      check(16'(n), 16'(24 + 32 * tv[i]), "slow length");
    end
    $display("test slow done");
  endtask

  task automatic t_blank;
    int n;
    int bl[4] = '{16, 24, 36, 54};
    for (int c = 0; c < 4; c++) begin
      wr(mk(c, 1, 0, 0, 3, 0, 2));
      span(3, n);
      span(3, n);
      check(16'(n), 16'(bl[c]), "blanking length");
    end
    $display("test blank done");
  endtask

  task automatic t_fast;
    int n;
    fast_dly = 10'h005;
    wr(mk(0, 1, 0, 3, 3, 1, 2));
    span(1, n);
    span(1, n);
    check(16'(n), 16'd288, "timer-only fast length");
    fast_dly = 10'h028;
    wr(mk(0, 1, 0, 1, 3, 1, 2));
    span(1, n);
    span(1, n);
    check({15'h0, n >= 16 && n < 288}, 16'h1, "early fast end");
    $display("test fast done");
  endtask

  task automatic t_levels;
    int n;
    fast_dly = 10'h010;
    wr(mk(0, 0, 0, 0, 5, 3, 2));
    span(0, n);
    span(2, n);
    @(posedge phase_on);
    @(negedge clk);
    check(hyst_level, 6'h06, "hysteresis start");
    check(sine_offset, 6'h00, "offset in mode 0");
    repeat (16) @(negedge clk);
    check(hyst_level, 6'h05, "first decrement");
    wr(mk(0, 1, 0, 0, 0, 0, 2));
    repeat (3) @(negedge clk);
    check(sine_offset, 6'h3d, "low offset");
    check(hyst_level, 6'h00, "level in mode 1");
    wr(mk(0, 1, 0, 0, 15, 0, 2));
    repeat (3) @(negedge clk);
    check(sine_offset, 6'h0c, "high offset");
    $display("test levels done");
  endtask

  task automatic t_rand;
    int n;
    int lo = 9999;
    int hi = 0;
    wr(mk(0, 1, 1, 0, 3, 0, 2));
    span(2, n);
    repeat (8) begin
      span(2, n);
      lo = n < lo ? n : lo;
      hi = n > hi ? n : hi;
    end
    check({15'h0, lo >= 88 && hi <= 91}, 16'h1, "random bound");
    check({15'h0, hi != lo}, 16'h1, "random spread");
    $display("test rand done");
  endtask

  task automatic t_disable;
    int n;
    wr(mk(0, 1, 0, 0, 3, 0, 2));
    span(0, n);
    wr(mk(0, 1, 0, 0, 3, 0, 0));
    repeat (2) @(negedge clk);
    check(bridges_off, 1'b1, "disable");
    check(ph, 4'h0, "phases when disabled");
    wr(mk(0, 1, 0, 0, 3, 0, 2));
    repeat (4) @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check(bridges_off, 1'b1, "settings cleared by reset");
    $display("test disable done");
  endtask

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_select();
    t_slow();
    t_blank();
    t_fast();
    t_levels();
    t_rand();
    t_disable();
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
